// file: src/msd_consts.svh
// constants for the micro-step serial front end and decay table
// assumes a 100 MHz system clock and 32-bit avalon-mm byte addressing
`ifndef MSD_CONSTS_SVH
`define MSD_CONSTS_SVH

`define MSD_WORD_BITS      16
`define MSD_TABLE_DEFAULT  16'hFDA0
`define MSD_SLOTS          4'h8
`define MSD_OFS_DRIVE      5'h00
`define MSD_OFS_TABLE      5'h04
`define MSD_OFS_STATUS     5'h08
`define MSD_OFS_SLOT_LEN   5'h0C
`define MSD_OFS_SHIFT      5'h10
`define MSD_SLOT_LEN_RST   16'h007D
`define MSD_ST_SETUP       0
`define MSD_ST_EXT_RST_N   1
`define MSD_ST_INT_RST     2
`define MSD_ST_OFF_A       3
`define MSD_ST_OFF_B       4
`define MSD_ST_FAST_A      5
`define MSD_ST_FAST_B      6

`endif

// file: src/msd_pkg.sv
// types for the micro-step serial front end
// assumes msd_consts.svh for numbers
package msd_pkg;

    typedef struct packed {
        logic       mix;
        logic [2:0] ratio;
    } msd_entry_type;

    typedef struct packed {
        logic       phase_a;
        logic [3:0] cur_a;
        logic [1:0] decay_a;
        logic       phase_b;
        logic [3:0] cur_b;
        logic [1:0] decay_b;
        logic [1:0] torque;
    } msd_drive_type;

    typedef struct packed {
        logic       off;
        logic       polarity;
        logic [3:0] code;
        logic       fast;
    } msd_phase_type;

    typedef enum logic [0:0] {
        MSD_BUS_IDLE = 1'b0,
        MSD_BUS_RESP = 1'b1
    } msd_bus_state_type;

endpackage

// file: src/msd_sync.sv
// two-flop synchroniser for a bundle of level inputs
// assumes each bit is independent; no multi-bit coherence is promised
`timescale 1ns/1ps
module msd_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    // data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule

// file: src/msd_top.sv
// serial input, drive latch and mixed decay timing table for one motor unit
// assumes pins are asynchronous to clk_sys_i; rst_i is the logic supply
// power-on reset and is the only thing that restores the table defaults
//
// Overview of operation
// - each phase current code is 4 bits, sixteen steps from 0 to 90 degrees
// - setup pin high routes words to decay table, low to drive settings
// - every transfer is sixteen data bits, bit 0 first, bit 15 last
// - data sampled on serial clock fall, shifted on serial clock rise
// - strobe rising edge copies all sixteen bits at once; otherwise hold
// - setup word holds four 4-bit entries, top bit mix flag, low three ratio
// - external reset low keeps shift register clear, blocking table writes
// - thermal, overcurrent or supply faults block table rewriting
// - table defaults: slow, 37.5 percent, 75 percent, full fast
// - table returns to defaults only on logic supply reset
// - entering setup keeps old table until a setup word is latched
// - mix flag low means 0 percent; else (k+1) eighths fast decay
// - fast decay interval sits at the end of each chopping period
// - only the 100 percent setting gives full fast decay
// - each phase 2-bit decay select picks one of four table entries
// - current code of zero switches that phase fully off
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module msd_top (
    // system
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    // avalon-mm slave
    input  wire logic [4:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    // serial pins
    input  wire logic                 ser_clk_i,
    input  wire logic                 ser_data_i,
    input  wire logic                 strobe_i,
    input  wire logic                 ext_reset_n_i,
    input  wire logic                 setup_i,
    // supervisory inputs, high when tripped or out of range
    input  wire logic                 thermal_shutdown_i,
    input  wire logic                 overcurrent_shutdown_i,
    input  wire logic                 logic_supply_monitor_i,
    input  wire logic                 motor_supply_monitor_i,
    // drive outputs
    output msd_pkg::msd_phase_type    phase_a_o,
    output msd_pkg::msd_phase_type    phase_b_o,
    output logic      [1:0]           torque_o
);
`include "msd_consts.svh"

    // fast slots out of eight for one table entry
    function automatic logic [3:0] fast_slots(msd_pkg::msd_entry_type e);
        logic [3:0] n;
        n = 4'h0;
        if (e.mix) begin
            n = {1'b0, e.ratio} + 4'h1;
        end
        return n;
    endfunction

    // entry chosen by a 2-bit select
    function automatic msd_pkg::msd_entry_type pick(logic [15:0] t,
                                                    logic [1:0]  s);
        msd_pkg::msd_entry_type e;
        e = msd_pkg::msd_entry_type'(t[{s, 2'b00} +: 4]);
        return e;
    endfunction

    // pin synchronisers
    logic [8:0] pins_sync;

    msd_sync #(
        .W(9)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i    (rst_i),
        .async_i  ({~ser_clk_i, ser_data_i, strobe_i, ext_reset_n_i,
                    setup_i, thermal_shutdown_i, overcurrent_shutdown_i,
                    logic_supply_monitor_i, motor_supply_monitor_i}),
        .sync_o   (pins_sync)
    );

    logic sclk_s;
    logic sclk_n_s;
    logic sdata_s;
    logic stb_s;
    logic xrst_n_s;
    logic setup_s;
    logic tsd_s;
    logic isd_s;
    logic lsup_s;
    logic msup_s;

    // serial clock travels inverted so a cleared synchroniser reads as
    // the idle high level: no false edge right after reset
    assign {sclk_n_s, sdata_s, stb_s, xrst_n_s, setup_s,
            tsd_s, isd_s, lsup_s, msup_s} = pins_sync;
    assign sclk_s = ~sclk_n_s;

    // serial path state
    logic        sclk_ff;
    logic        stb_ff;
    logic        sample_ff;
    logic [15:0] shift_ff;
    logic [15:0] drive_ff;
    logic [15:0] table_ff;
    logic        nxt_sclk;
    logic        nxt_stb;
    logic        nxt_sample;
    logic [15:0] nxt_shift;
    logic [15:0] nxt_drive;
    logic [15:0] nxt_table;

    logic sclk_fall;
    logic sclk_rise;
    logic stb_rise;
    logic supply_bad;
    logic int_rst;

    assign sclk_fall  = sclk_ff & ~sclk_s;
    assign sclk_rise  = ~sclk_ff & sclk_s;
    assign stb_rise   = ~stb_ff & stb_s;
    assign supply_bad = lsup_s | msup_s;
    assign int_rst    = supply_bad | tsd_s | isd_s;

    always_comb begin
        nxt_sclk   = sclk_s;
        nxt_stb    = stb_s;
        nxt_sample = sample_ff;
        nxt_shift  = shift_ff;
        nxt_drive  = drive_ff;
        nxt_table  = table_ff;
        if (sclk_fall) begin
            nxt_sample = sdata_s;
        end
        if (!xrst_n_s || supply_bad) begin
            nxt_shift = 16'h0000;
        end else if (tsd_s || isd_s) begin
            nxt_shift = shift_ff;
        end else if (sclk_rise) begin
            // lsb first: the first bit ends up in bit 0
            nxt_shift = {sample_ff, shift_ff[15:1]};
        end
        // the controller keeps strobe low until all bits are in
        if (stb_rise) begin
            if (setup_s) begin
                if (xrst_n_s && !int_rst) begin
                    nxt_table = shift_ff;
                end
            end else begin
                nxt_drive = shift_ff;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_ff   <= 1'b1;
            stb_ff    <= 1'b0;
            sample_ff <= 1'b0;
            shift_ff  <= 16'h0000;
            drive_ff  <= 16'h0000;
            table_ff  <= `MSD_TABLE_DEFAULT;
        end else begin
            sclk_ff   <= nxt_sclk;
            stb_ff    <= nxt_stb;
            sample_ff <= nxt_sample;
            shift_ff  <= nxt_shift;
            drive_ff  <= nxt_drive;
            table_ff  <= nxt_table;
        end
    end

    // chopping slot timer
    logic [15:0] slot_len_ff;
    logic [15:0] slot_cnt_ff;
    logic [2:0]  slot_idx_ff;
    logic [15:0] nxt_slot_cnt;
    logic [2:0]  nxt_slot_idx;

    always_comb begin
        nxt_slot_cnt = slot_cnt_ff + 16'h0001;
        nxt_slot_idx = slot_idx_ff;
        if (slot_cnt_ff >= slot_len_ff - 16'h0001) begin
            nxt_slot_cnt = 16'h0000;
            nxt_slot_idx = slot_idx_ff + 3'h1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            slot_cnt_ff <= 16'h0000;
            slot_idx_ff <= 3'h0;
        end else begin
            slot_cnt_ff <= nxt_slot_cnt;
            slot_idx_ff <= nxt_slot_idx;
        end
    end

    // phase outputs
    msd_pkg::msd_drive_type drv;
    msd_pkg::msd_phase_type ph_a_ff;
    msd_pkg::msd_phase_type ph_b_ff;
    msd_pkg::msd_phase_type nxt_ph_a;
    msd_pkg::msd_phase_type nxt_ph_b;
    logic [1:0]             torque_ff;
    logic [1:0]             nxt_torque;
    logic [3:0]             fast_a;
    logic [3:0]             fast_b;
    logic [3:0]             slot_rem;
    logic                   out_off;

    assign drv      = msd_pkg::msd_drive_type'(drive_ff);
    assign fast_a   = fast_slots(pick(table_ff, drv.decay_a));
    assign fast_b   = fast_slots(pick(table_ff, drv.decay_b));
    // slots left in this period including the current one
    assign slot_rem = `MSD_SLOTS - {1'b0, slot_idx_ff};
    assign out_off  = !xrst_n_s || int_rst;

    always_comb begin
        nxt_torque        = drv.torque;
        nxt_ph_a.code     = drv.cur_a;
        nxt_ph_a.polarity = drv.phase_a;
        nxt_ph_a.off      = out_off || (drv.cur_a == 4'h0);
        // fast only in the last slots; eight slots means all fast
        nxt_ph_a.fast     = (slot_rem <= fast_a);
        nxt_ph_b.code     = drv.cur_b;
        nxt_ph_b.polarity = drv.phase_b;
        nxt_ph_b.off      = out_off || (drv.cur_b == 4'h0);
        nxt_ph_b.fast     = (slot_rem <= fast_b);
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ph_a_ff   <= '{off: 1'b1, polarity: 1'b0, code: 4'h0, fast: 1'b0};
            ph_b_ff   <= '{off: 1'b1, polarity: 1'b0, code: 4'h0, fast: 1'b0};
            torque_ff <= 2'h0;
        end else begin
            ph_a_ff   <= nxt_ph_a;
            ph_b_ff   <= nxt_ph_b;
            torque_ff <= nxt_torque;
        end
    end

    assign phase_a_o = ph_a_ff;
    assign phase_b_o = ph_b_ff;
    assign torque_o  = torque_ff;

    // avalon-mm slave: one wait cycle per access keeps decode off the
    // bus path at the cost of a cycle of latency
    msd_pkg::msd_bus_state_type bus_ff;
    msd_pkg::msd_bus_state_type nxt_bus;
    logic [31:0]                rdata_ff;
    logic [31:0]                nxt_rdata;
    logic [15:0]                nxt_slot_len;
    logic [31:0]                status_w;

    always_comb begin
        status_w                     = 32'h0000_0000;
        status_w[`MSD_ST_SETUP]      = setup_s;
        status_w[`MSD_ST_EXT_RST_N]  = xrst_n_s;
        status_w[`MSD_ST_INT_RST]    = int_rst;
        status_w[`MSD_ST_OFF_A]      = ph_a_ff.off;
        status_w[`MSD_ST_OFF_B]      = ph_b_ff.off;
        status_w[`MSD_ST_FAST_A]     = ph_a_ff.fast;
        status_w[`MSD_ST_FAST_B]     = ph_b_ff.fast;
    end

    always_comb begin
        nxt_bus      = msd_pkg::MSD_BUS_IDLE;
        nxt_rdata    = rdata_ff;
        nxt_slot_len = slot_len_ff;
        unique case (bus_ff)
            msd_pkg::MSD_BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    nxt_bus   = msd_pkg::MSD_BUS_RESP;
                    nxt_rdata = 32'h0000_0000;
                    if (avs_read_i) begin
                        case (avs_address_i)
                            `MSD_OFS_DRIVE:    nxt_rdata = {16'h0000, drive_ff};
                            `MSD_OFS_TABLE:    nxt_rdata = {16'h0000, table_ff};
                            `MSD_OFS_STATUS:   nxt_rdata = status_w;
                            `MSD_OFS_SLOT_LEN: nxt_rdata = {16'h0000,
                                                            slot_len_ff};
                            `MSD_OFS_SHIFT:    nxt_rdata = {16'h0000, shift_ff};
                            default:           nxt_rdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            msd_pkg::MSD_BUS_RESP: begin
                // zero would stretch each slot to 65536 cycles, so it is refused
                if (avs_write_i && avs_address_i == `MSD_OFS_SLOT_LEN &&
                    avs_writedata_i[15:0] != 16'h0000) begin
                    nxt_slot_len = avs_writedata_i[15:0];
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bus_ff      <= msd_pkg::MSD_BUS_IDLE;
            rdata_ff    <= 32'h0000_0000;
            slot_len_ff <= `MSD_SLOT_LEN_RST;
        end else begin
            bus_ff      <= nxt_bus;
            rdata_ff    <= nxt_rdata;
            slot_len_ff <= nxt_slot_len;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) &&
                               (bus_ff == msd_pkg::MSD_BUS_IDLE);
    assign avs_readdata_o    = rdata_ff;

endmodule

// file: testbench/msd_top_monitor.sv
// concurrent checks on the ports of msd_top
// assumes it is bound to msd_top and sees only its ports
`timescale 1ns/1ps
module msd_top_monitor (
    // system
    input wire logic                   clk_sys_i,
    input wire logic                   rst_i,
    // bus handshake
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic                   avs_waitrequest_o,
    // pins
    input wire logic                   strobe_i,
    input wire logic                   ext_reset_n_i,
    input wire logic                   setup_i,
    input wire logic                   thermal_shutdown_i,
    input wire logic                   overcurrent_shutdown_i,
    input wire logic                   logic_supply_monitor_i,
    input wire logic                   motor_supply_monitor_i,
    // drive outputs
    input wire msd_pkg::msd_phase_type phase_a_o,
    input wire msd_pkg::msd_phase_type phase_b_o,
    input wire logic [1:0]             torque_o
);
    // cycles since strobe was high; saturates so it never wraps
    logic [3:0] stb_age_ff;
    logic [3:0] nxt_stb_age;
    logic       fault;
    assign fault = thermal_shutdown_i | overcurrent_shutdown_i |
                   logic_supply_monitor_i | motor_supply_monitor_i;
    always_comb begin
        nxt_stb_age = stb_age_ff;
        if (strobe_i) begin
            nxt_stb_age = 4'h0;
        end else if (stb_age_ff != 4'hF) begin
            nxt_stb_age = stb_age_ff + 4'h1;
        end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            stb_age_ff <= 4'hF;
        end else begin
            stb_age_ff <= nxt_stb_age;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wait_first_a: assert property (
        $rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o)
        else $error("no wait state in first request cycle");
    wait_one_a: assert property (
        (avs_read_i | avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("more than one wait state");
    latch_hold_a: assert property (
        $changed(torque_o) |-> stb_age_ff < 4'h8)
        else $error("torque changed without strobe");
    setup_route_a: assert property (
        setup_i [*8] |-> $stable(torque_o))
        else $error("setup word reached drive latch");
    ext_off_a: assert property (
        !ext_reset_n_i [*6] |-> phase_a_o.off && phase_b_o.off)
        else $error("phase on under external reset");
    fault_off_a: assert property (
        fault [*6] |-> phase_a_o.off && phase_b_o.off)
        else $error("phase on under internal reset");
    zero_off_a: assert property (
        phase_a_o.code == 4'h0 |-> phase_a_o.off)
        else $error("phase a on with zero code");
    zero_off_b_a: assert property (
        phase_b_o.code == 4'h0 |-> phase_b_o.off)
        else $error("phase b on with zero code");
    cover property (phase_a_o.fast && !phase_b_o.fast);
    cover property (setup_i && $rose(strobe_i));
    cover property (avs_write_i && !avs_waitrequest_o);
endmodule

// file: testbench/msd_ctl_model.sv
// serial controller model: clock, data and strobe pins
// assumes a 100 MHz clk_sys_i; link clock 160 ns, idle high
`timescale 1ns/1ps
module msd_ctl_model (
    // system
    input  wire logic clk_sys_i,
    // serial pins
    output logic      ser_clk_o,
    output logic      ser_data_o,
    output logic      strobe_o
);
    initial begin
        ser_clk_o = 1'b1;
        ser_data_o = 1'b0;
        strobe_o = 1'b0;
    end
    task automatic send(input logic [15:0] w);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys_i);
            ser_data_o <= w[i];
            // data settles well before the falling edge samples it
            repeat (4) @(posedge clk_sys_i);
            ser_clk_o <= 1'b0;
            repeat (8) @(posedge clk_sys_i);
            ser_clk_o <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
        end
        repeat (5) @(posedge clk_sys_i);
        strobe_o <= 1'b1;
        ser_data_o <= ~w[15];
        repeat (6) @(posedge clk_sys_i);
        strobe_o <= 1'b0;
    endtask
endmodule

// file: testbench/msd_top_tb_top.sv
// self-checking bench for the serial front end and decay table
// assumes msd_pkg, msd_top and the model and monitor compiled first
`timescale 1ns/1ps
module msd_top_tb_top;
    logic                   clk_sys_i = 1'b0;
    logic                   rst_i = 1'b1;
    logic [4:0]             avs_address_i = 5'h00;
    logic                   avs_read_i = 1'b0;
    logic                   avs_write_i = 1'b0;
    logic [31:0]            avs_writedata_i = 32'h0;
    logic [31:0]            avs_readdata_o;
    logic                   avs_waitrequest_o;
    logic                   ser_clk;
    logic                   ser_data;
    logic                   strobe;
    logic                   ext_reset_n_i = 1'b1;
    logic                   setup_i = 1'b0;
    logic [3:0]             flt = 4'h0;
    msd_pkg::msd_phase_type phase_a_o;
    msd_pkg::msd_phase_type phase_b_o;
    logic [1:0]             torque_o;
    msd_pkg::msd_drive_type dw;
    logic [15:0]            tw;
    logic [15:0]            cur_t = 16'hFDA0;
    logic [31:0]            rnd = 32'hB7EE;
    logic [31:0]            exp_q[$];
    int                     fail_count = 0;
    int                     checked = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    msd_ctl_model ctl (.clk_sys_i(clk_sys_i), .ser_clk_o(ser_clk),
        .ser_data_o(ser_data), .strobe_o(strobe));
    msd_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .ser_clk_i(ser_clk),
        .ser_data_i(ser_data), .strobe_i(strobe),
        .ext_reset_n_i(ext_reset_n_i), .setup_i(setup_i),
        .thermal_shutdown_i(flt[0]), .overcurrent_shutdown_i(flt[1]),
        .logic_supply_monitor_i(flt[2]), .motor_supply_monitor_i(flt[3]),
        .phase_a_o(phase_a_o), .phase_b_o(phase_b_o),
        .torque_o(torque_o));
    function automatic void xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
    endfunction
    function automatic logic [31:0] fexp(input logic [3:0] e);
        return e[3] ? ({29'h0, e[2:0]} + 32'h1) << 1 : 32'h0;
    endfunction
    task automatic check(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= ~w;
        avs_writedata_i <= d;
        // request stands until waitrequest is seen low at a rising edge
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // read data are taken at the edge where waitrequest is seen low
    always @(posedge clk_sys_i)
        if (avs_read_i && avs_waitrequest_o === 1'b0)
            check("readdata", avs_readdata_o, exp_q.pop_front());
    task automatic frame(input logic [15:0] w);
        ctl.send(w);
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic fast_chk(input logic [3:0] ea, input logic [3:0] eb);
        logic [31:0] na;
        logic [31:0] nb;
        na = 32'h0;
        nb = 32'h0;
        repeat (16) begin
            @(negedge clk_sys_i);
            na += {31'h0, phase_a_o.fast};
            nb += {31'h0, phase_b_o.fast};
        end
        check("fast_a", na, fexp(ea));
        check("fast_b", nb, fexp(eb));
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(5'h04, 32'h0000FDA0);
        rd(5'h0C, 32'h0000007D);
        bus(1'b1, 5'h14, 32'hFFFF);
        rd(5'h14, 32'h0);
        // short chopping period keeps the decay checks brief
        bus(1'b1, 5'h0C, 32'h2);
        rd(5'h0C, 32'h2);
        // a zero slot length would stretch each slot to 65536 cycles and is ignored
        bus(1'b1, 5'h0C, 32'h0);
        rd(5'h0C, 32'h2);
        for (int n = 0; n < 17; n++) begin
            xs();
            dw = rnd[15:0];
            dw.cur_a = (n > 15) ? 4'hF : n[3:0];
            dw.cur_b = (n == 0) ? 4'hF : 4'(16 - n);
            frame(dw);
            rd(5'h00, {16'h0, dw});
            @(negedge clk_sys_i);
            check("phase_a", phase_a_o[6:1],
                  {dw.cur_a == 4'h0, dw.phase_a, dw.cur_a});
            check("phase_b", phase_b_o[6:1],
                  {dw.cur_b == 4'h0, dw.phase_b, dw.cur_b});
            check("torque", torque_o, dw.torque);
            if (n > 0 && n < 16)
                fast_chk(cur_t[4 * dw.decay_a +: 4],
                         cur_t[4 * dw.decay_b +: 4]);
        end
        for (int i = 0; i < 4; i++) begin
            frame(16'h0000);
            setup_i <= 1'b1;
            rd(5'h04, {16'h0, cur_t});
            xs();
            tw = {1'b0, rnd[2:0], rnd[7:4],
                  1'b1, 3'(2 * i + 1), 1'b1, 3'(2 * i)};
            frame(tw);
            rd(5'h04, {16'h0, tw});
            rd(5'h00, 32'h0);
            cur_t = tw;
            setup_i <= 1'b0;
            for (int d = 0; d < 4; d++) begin
                xs();
                dw = rnd[15:0];
                dw.cur_a[0] = 1'b1;
                dw.cur_b[0] = 1'b1;
                dw.decay_a = 2'(d);
                dw.decay_b = 2'(3 - d);
                frame(dw);
                fast_chk(tw[4 * d +: 4], tw[12 - 4 * d +: 4]);
            end
        end
        frame(16'h0000);
        setup_i <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            flt <= 4'h1 << f;
            frame(~cur_t);
            flt <= 4'h0;
            rd(5'h04, {16'h0, cur_t});
        end
        ext_reset_n_i <= 1'b0;
        frame(~cur_t);
        rd(5'h10, 32'h0);
        rd(5'h04, {16'h0, cur_t});
        ext_reset_n_i <= 1'b1;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(5'h04, 32'h0000FDA0);
        final_report();
    end
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        fail_count++;
        final_report();
    end
endmodule
bind msd_top msd_top_monitor mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .strobe_i(strobe_i),
    .ext_reset_n_i(ext_reset_n_i), .setup_i(setup_i),
    .thermal_shutdown_i(thermal_shutdown_i),
    .overcurrent_shutdown_i(overcurrent_shutdown_i),
    .logic_supply_monitor_i(logic_supply_monitor_i),
    .motor_supply_monitor_i(motor_supply_monitor_i),
    .phase_a_o(phase_a_o), .phase_b_o(phase_b_o), .torque_o(torque_o));
